// ### hdl/phi_defines.svh
// Timing and field constants for the pipeline hazard interlock.
`ifndef PHI_DEFINES_SVH
`define PHI_DEFINES_SVH
`define PHI_REG_W 5
`define PHI_XLEN 32
`define PHI_SYS_W 5
`define PHI_LOAD_BUBBLES 2'h1
`define PHI_SYSREG_BUBBLES 2'h2
`define PHI_MULW_DIST 3'h5
`define PHI_MULH_DIST 3'h2
`define PHI_ALIGN_CLKS 3'h4
`define PHI_ZERO_REG 5'h00
`define PHI_SYS_IRQ_RET 5'h00
`define PHI_SYS_FAULT_RET 5'h02
`endif

// ### hdl/phi_pkg.sv
// Types shared by the pipeline hazard interlock.
`include "phi_defines.svh"
package phi_pkg;
  typedef enum logic [2:0] {
    PHI_OP_ALU,
    PHI_OP_LOAD,
    PHI_OP_MULH,
    PHI_OP_MULW,
    PHI_OP_SYSW,
    PHI_OP_SYSR,
    PHI_OP_BRANCH,
    PHI_OP_OTHER
  } phi_op_t;

  typedef struct packed {
    logic valid;
    phi_op_t op;
    logic [`PHI_REG_W-1:0] src_a;
    logic [`PHI_REG_W-1:0] src_b;
    logic [`PHI_REG_W-1:0] dst;
    logic [`PHI_SYS_W-1:0] sys_sel;
  } phi_instr_t;

  typedef enum logic [1:0] {
    PHI_FWD_NONE,
    PHI_FWD_OPERATE,
    PHI_FWD_ACCESS,
    PHI_FWD_SECOND
  } phi_fwd_t;

  typedef enum {
    PHI_FETCH_RUN,
    PHI_FETCH_HALF2
  } phi_fetch_st_t;

  typedef struct packed {
    phi_fetch_st_t fetch_st;
    phi_instr_t opr;
    phi_instr_t acc;
    phi_instr_t cmt;
    logic [2:0] mulw_left;
    logic [`PHI_REG_W-1:0] mulw_dst;
    logic [1:0] bubble_cnt;
    phi_fwd_t fwd_a;
    phi_fwd_t fwd_b;
    logic [`PHI_XLEN-1:0] fwd_data;
    logic stall;
    logic refetch;
  } phi_state_t;
endpackage

// ### hdl/phi_interlock.sv
// Hazard detection, interlock and forwarding control for the five-stage pipeline.
`timescale 1ns/100ps
`include "phi_defines.svh"

// Behaviour
// - Five in-order stages, one clock each normally.
// - Misaligned 4-byte branch target fetched twice.
// - Branch takes four clocks on misaligned target.
// - No double fetch for aligned or short targets.
// - Load-use dependency stalls following decode.
// - Load data forwarded from access into decode.
// - Load with immediate consumer takes two clocks.
// - No load stall at distance two or more.
// - Multiply-use dependency stalls following decode.
// - Product forwarded from second operate into decode.
// - Halfword multiply no stall at distance two.
// - Word multiply consumers under five stalled until product ready.
// - Return-address write then read stalls read.
// - That system write takes three clocks.
// - No system stall at distance three or more.
// - Fetch and data access use independent ports.
// - Operate results forwarded, no stall.
module phi_interlock #(
  parameter int XLEN = `PHI_XLEN
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Decode stage instruction and branch target info
  input wire phi_pkg::phi_instr_t decode_i,
  input wire logic branch_taken_i,
  input wire logic target_long_i,
  input wire logic addr_bit1_i,
  input wire logic addr_bit0_i,
  // Results available for forwarding
  input wire logic [XLEN-1:0] operate_result_i,
  input wire logic [XLEN-1:0] access_data_i,
  input wire logic [XLEN-1:0] product_i,
  input wire logic product_ready_i,
  // Independent fetch and data ports
  input wire logic fetch_req_i,
  input wire logic access_req_i,
  output logic fetch_grant_o,
  output logic access_grant_o,
  // Pipeline control
  output logic stall_o,
  output logic interlock_bubble_o,
  output logic refetch_o,
  output phi_pkg::phi_fwd_t fwd_a_o,
  output phi_pkg::phi_fwd_t fwd_b_o,
  output logic [XLEN-1:0] fwd_data_o,
  output phi_pkg::phi_instr_t operate_stage_o,
  output phi_pkg::phi_instr_t access_stage_o,
  output phi_pkg::phi_instr_t register_commit_stage_o
);
  phi_pkg::phi_state_t st_r;
  phi_pkg::phi_state_t st_nxt;

  logic uses_a;
  logic uses_b;
  logic dep_opr_a;
  logic dep_opr_b;
  logic dep_mulw_a;
  logic dep_mulw_b;
  logic hz_load;
  logic hz_mulh;
  logic hz_mulw;
  logic hz_sys;
  logic misaligned;
  phi_pkg::phi_instr_t bubble;

  function automatic logic reads_reg(input logic [`PHI_REG_W-1:0] src, input logic [`PHI_REG_W-1:0] dst);
    reads_reg = (src == dst) && (dst != `PHI_ZERO_REG);
  endfunction

  function automatic logic is_ret_pc(input logic [`PHI_SYS_W-1:0] sel);
    is_ret_pc = (sel == `PHI_SYS_IRQ_RET) || (sel == `PHI_SYS_FAULT_RET);
  endfunction

  always_comb begin
    bubble = '0;
    bubble.op = phi_pkg::PHI_OP_OTHER;
    uses_a = decode_i.valid && (decode_i.op != phi_pkg::PHI_OP_SYSR);
    uses_b = decode_i.valid && (decode_i.op != phi_pkg::PHI_OP_SYSR);
    // Only a real register match counts as a dependency.
    dep_opr_a = uses_a && st_r.opr.valid && reads_reg(decode_i.src_a, st_r.opr.dst);
    dep_opr_b = uses_b && st_r.opr.valid && reads_reg(decode_i.src_b, st_r.opr.dst);
    dep_mulw_a = uses_a && (st_r.mulw_left != 3'h0) && reads_reg(decode_i.src_a, st_r.mulw_dst);
    dep_mulw_b = uses_b && (st_r.mulw_left != 3'h0) && reads_reg(decode_i.src_b, st_r.mulw_dst);
    hz_load = (dep_opr_a || dep_opr_b) && (st_r.opr.op == phi_pkg::PHI_OP_LOAD);
    hz_mulh = (dep_opr_a || dep_opr_b) && (st_r.opr.op == phi_pkg::PHI_OP_MULH);
    // A word product keeps its consumers waiting until the multiplier signals ready.
    hz_mulw = (dep_mulw_a || dep_mulw_b) && !product_ready_i;
    hz_sys = decode_i.valid && (decode_i.op == phi_pkg::PHI_OP_SYSR) && is_ret_pc(decode_i.sys_sel) &&
             ((st_r.opr.valid && st_r.opr.op == phi_pkg::PHI_OP_SYSW && st_r.opr.sys_sel == decode_i.sys_sel) ||
              (st_r.acc.valid && st_r.acc.op == phi_pkg::PHI_OP_SYSW && st_r.acc.sys_sel == decode_i.sys_sel &&
               st_r.bubble_cnt != 2'h0));
    misaligned = branch_taken_i && target_long_i && addr_bit1_i && !addr_bit0_i;

    st_nxt = st_r;
    st_nxt.refetch = 1'b0;
    st_nxt.fwd_a = phi_pkg::PHI_FWD_NONE;
    st_nxt.fwd_b = phi_pkg::PHI_FWD_NONE;

    unique case (st_r.fetch_st)
      phi_pkg::PHI_FETCH_RUN: begin
        if (misaligned) begin
          st_nxt.fetch_st = phi_pkg::PHI_FETCH_HALF2;
          st_nxt.refetch = 1'b1;
        end
      end
      phi_pkg::PHI_FETCH_HALF2: begin
        // Second halfword fetch completes; the extra clock gives the branch its four clocks.
        st_nxt.fetch_st = phi_pkg::PHI_FETCH_RUN;
      end
    endcase

    st_nxt.stall = hz_load || hz_mulh || hz_mulw || hz_sys;

    // Bubble count: system write two bubbles (three clocks); a load's one bubble comes from its stall alone, not this count.
    if (hz_sys && st_r.bubble_cnt == 2'h0 && st_r.opr.op == phi_pkg::PHI_OP_SYSW) begin
      st_nxt.bubble_cnt = `PHI_SYSREG_BUBBLES - 2'h1;
    end else if (st_r.bubble_cnt != 2'h0) begin
      st_nxt.bubble_cnt = st_r.bubble_cnt - 2'h1;
    end

    // Advance the stages; a stall injects a bubble into operate.
    st_nxt.cmt = st_r.acc;
    st_nxt.acc = st_r.opr;
    st_nxt.opr = st_nxt.stall ? bubble : decode_i;

    if (st_r.mulw_left != 3'h0 && !st_nxt.stall) begin
      st_nxt.mulw_left = st_r.mulw_left - 3'h1;
    end
    if (!st_nxt.stall && decode_i.valid && decode_i.op == phi_pkg::PHI_OP_MULW) begin
      st_nxt.mulw_left = `PHI_MULW_DIST - 3'h1;
      st_nxt.mulw_dst = decode_i.dst;
    end

    // Forward select for the instruction leaving decode this clock.
    st_nxt.fwd_data = st_r.fwd_data;
    if (!st_nxt.stall) begin
      if (dep_opr_a || dep_opr_b) begin
        st_nxt.fwd_data = operate_result_i;
        st_nxt.fwd_a = dep_opr_a ? phi_pkg::PHI_FWD_OPERATE : phi_pkg::PHI_FWD_NONE;
        st_nxt.fwd_b = dep_opr_b ? phi_pkg::PHI_FWD_OPERATE : phi_pkg::PHI_FWD_NONE;
      end
      if (st_r.acc.valid && st_r.acc.op == phi_pkg::PHI_OP_LOAD &&
          (reads_reg(decode_i.src_a, st_r.acc.dst) || reads_reg(decode_i.src_b, st_r.acc.dst))) begin
        st_nxt.fwd_data = access_data_i;
        st_nxt.fwd_a = reads_reg(decode_i.src_a, st_r.acc.dst) ? phi_pkg::PHI_FWD_ACCESS : st_nxt.fwd_a;
        st_nxt.fwd_b = reads_reg(decode_i.src_b, st_r.acc.dst) ? phi_pkg::PHI_FWD_ACCESS : st_nxt.fwd_b;
      end
      if ((st_r.acc.valid && st_r.acc.op == phi_pkg::PHI_OP_MULH &&
           (reads_reg(decode_i.src_a, st_r.acc.dst) || reads_reg(decode_i.src_b, st_r.acc.dst))) ||
          dep_mulw_a || dep_mulw_b) begin
        st_nxt.fwd_data = product_i;
        st_nxt.fwd_a = phi_pkg::PHI_FWD_SECOND;
        st_nxt.fwd_b = phi_pkg::PHI_FWD_SECOND;
      end
    end
    if (!decode_i.valid) begin
      st_nxt.fwd_a = phi_pkg::PHI_FWD_NONE;
      st_nxt.fwd_b = phi_pkg::PHI_FWD_NONE;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
      st_r.fetch_st <= phi_pkg::PHI_FETCH_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Fetch and data access sit on separate ports, so both are granted in the same clock.
  assign fetch_grant_o = fetch_req_i && !sys_rst_i;
  assign access_grant_o = access_req_i && !sys_rst_i;
  assign stall_o = st_r.stall;
  assign interlock_bubble_o = st_r.stall;
  assign refetch_o = st_r.refetch;
  assign fwd_a_o = st_r.fwd_a;
  assign fwd_b_o = st_r.fwd_b;
  assign fwd_data_o = st_r.fwd_data;
  assign operate_stage_o = st_r.opr;
  assign access_stage_o = st_r.acc;
  assign register_commit_stage_o = st_r.cmt;
endmodule

// ### testbench/phi_interlock_monitor.sv
// Checker of stalls, forwarding, refetch and port grants of the interlock.
`timescale 1ns/100ps
`include "phi_defines.svh"
module phi_interlock_monitor (
  // Clock, reset and inputs
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire phi_pkg::phi_instr_t decode_i,
  input wire logic branch_taken_i,
  input wire logic target_long_i,
  input wire logic addr_bit1_i,
  input wire logic addr_bit0_i,
  input wire logic fetch_req_i,
  input wire logic access_req_i,
  // Observed outputs
  input wire logic fetch_grant_o,
  input wire logic access_grant_o,
  input wire logic stall_o,
  input wire logic refetch_o,
  input wire phi_pkg::phi_fwd_t fwd_a_o,
  input wire phi_pkg::phi_instr_t operate_stage_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic dep;
  logic odd;
  logic sys;
  // Antecedents need no stall in progress, since a stalled cycle shows the same decode again.
  assign dep = decode_i.valid && operate_stage_o.valid && operate_stage_o.dst != `PHI_ZERO_REG
    && decode_i.src_a == operate_stage_o.dst && !stall_o;
  assign odd = branch_taken_i && target_long_i && addr_bit1_i && !addr_bit0_i;
  assign sys = decode_i.valid && decode_i.op == phi_pkg::PHI_OP_SYSR && operate_stage_o.valid
    && operate_stage_o.op == phi_pkg::PHI_OP_SYSW && decode_i.sys_sel == operate_stage_o.sys_sel
    && (decode_i.sys_sel == `PHI_SYS_IRQ_RET || decode_i.sys_sel == `PHI_SYS_FAULT_RET) && !stall_o;
  sequence s_ld_wait;
    stall_o ##1 (!stall_o && fwd_a_o == phi_pkg::PHI_FWD_ACCESS);
  endsequence
  sequence s_sys_wait;
    stall_o [*2] ##1 !stall_o;
  endsequence
  AST_FETCH_GRANT: assert property (fetch_grant_o == fetch_req_i)
    else $error("fetch grant differs from request");
  AST_ACCESS_GRANT: assert property (access_grant_o == access_req_i)
    else $error("access grant differs from request");
  AST_LOAD_WAIT: assert property (dep && operate_stage_o.op == phi_pkg::PHI_OP_LOAD |=> s_ld_wait)
    else $error("load use not held for one cycle then forwarded");
  AST_ALU_FWD: assert property (dep && operate_stage_o.op == phi_pkg::PHI_OP_ALU |=> !stall_o
    && fwd_a_o == phi_pkg::PHI_FWD_OPERATE)
    else $error("operate result not forwarded");
  AST_MULH_WAIT: assert property (dep && operate_stage_o.op == phi_pkg::PHI_OP_MULH |=> stall_o)
    else $error("multiply use not stalled");
  AST_SYS_WAIT: assert property (sys |=> s_sys_wait)
    else $error("system write then read not stalled two cycles");
  AST_REFETCH: assert property (odd && !refetch_o |=> refetch_o)
    else $error("misaligned long target not fetched twice");
  AST_NO_REFETCH: assert property (branch_taken_i && !odd && !refetch_o |=> !refetch_o)
    else $error("refetch on aligned or short target");
  AST_INDEP: assert property (dep == 1'b0 && decode_i.valid && decode_i.op == phi_pkg::PHI_OP_ALU
    && operate_stage_o.op == phi_pkg::PHI_OP_LOAD && decode_i.src_b != operate_stage_o.dst && !stall_o
    |=> !stall_o)
    else $error("stall without dependency");
endmodule
bind phi_interlock phi_interlock_monitor mon_u (.clock_i, .sys_rst_i, .decode_i, .branch_taken_i,
  .target_long_i, .addr_bit1_i, .addr_bit0_i, .fetch_req_i, .access_req_i, .fetch_grant_o,
  .access_grant_o, .stall_o, .refetch_o, .fwd_a_o, .operate_stage_o);

// ### testbench/phi_mem_model.sv
// Far-side memory paths; fetch and data sides request independently.
`timescale 1ns/100ps
module phi_mem_model (
  // Clock
  input wire logic clock_i,
  // Path requests and result sources
  output logic fetch_req_o,
  output logic access_req_o,
  output logic [31:0] access_data_o,
  output logic [31:0] operate_result_o,
  output logic [31:0] product_o
);
  logic [31:0] cnt_r = 32'h00000000;
  always @(negedge clock_i) cnt_r <= cnt_r + 32'h00000001;
  // Fetch asks every cycle so data requests always overlap it.
  assign fetch_req_o = 1'b1;
  assign access_req_o = cnt_r[0];
  // Sources change every cycle so a stale forward cannot pass unseen.
  assign access_data_o = ~cnt_r;
  assign operate_result_o = cnt_r;
  assign product_o = {cnt_r[15:0], cnt_r[31:16]};
endmodule

// ### testbench/phi_interlock_tb.sv
// Self-checking bench for the pipeline hazard interlock.
`timescale 1ns/100ps
module phi_interlock_tb;
  typedef struct {phi_pkg::phi_op_t op_a; phi_pkg::phi_op_t op_b; logic [4:0] rg; logic [4:0] rg_b; logic exp;} phi_row_t;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  phi_pkg::phi_instr_t decode_i = '0;
  logic branch_taken_i = 1'b0;
  logic target_long_i = 1'b0;
  logic addr_bit1_i = 1'b0;
  logic addr_bit0_i = 1'b0;
  logic product_ready_i = 1'b1;
  logic fetch_req_i, access_req_i, fetch_grant_o, access_grant_o, stall_o, interlock_bubble_o, refetch_o;
  logic [31:0] operate_result_i, access_data_i, product_i, fwd_data_o;
  phi_pkg::phi_fwd_t fwd_a_o, fwd_b_o;
  phi_pkg::phi_instr_t operate_stage_o, access_stage_o, register_commit_stage_o;
  int failures = 0;
  int n_compared = 0;
  logic [3:0] br_tab [3] = '{4'hE, 4'hC, 4'hA};
  phi_row_t rows [8] = '{
    '{phi_pkg::PHI_OP_LOAD, phi_pkg::PHI_OP_ALU, 5'h06, 5'h06, 1'b1},
    '{phi_pkg::PHI_OP_LOAD, phi_pkg::PHI_OP_ALU, 5'h06, 5'h08, 1'b0},
    '{phi_pkg::PHI_OP_ALU, phi_pkg::PHI_OP_ALU, 5'h06, 5'h06, 1'b0},
    '{phi_pkg::PHI_OP_MULH, phi_pkg::PHI_OP_ALU, 5'h06, 5'h06, 1'b1},
    '{phi_pkg::PHI_OP_SYSW, phi_pkg::PHI_OP_SYSR, 5'h00, 5'h00, 1'b1},
    '{phi_pkg::PHI_OP_SYSW, phi_pkg::PHI_OP_SYSR, 5'h02, 5'h02, 1'b1},
    '{phi_pkg::PHI_OP_SYSW, phi_pkg::PHI_OP_SYSR, 5'h00, 5'h02, 1'b0},
    '{phi_pkg::PHI_OP_LOAD, phi_pkg::PHI_OP_ALU, 5'h00, 5'h00, 1'b0}};
  phi_interlock dut_u (.*);
  phi_mem_model mem_u (.clock_i, .fetch_req_o(fetch_req_i), .access_req_o(access_req_i),
    .access_data_o(access_data_i), .operate_result_o(operate_result_i), .product_o(product_i));
  function automatic phi_pkg::phi_instr_t mk(phi_pkg::phi_op_t op, logic [4:0] s, logic [4:0] d);
    // A system write names its target in the destination slot and a system read in the source slot.
    return '{1'b1, op, s, 5'h00, d, (op == phi_pkg::PHI_OP_SYSR) ? s : d};
  endfunction
  task automatic chk(input string nm, input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic send(input phi_pkg::phi_instr_t i);
    @(negedge clock_i);
    decode_i = i;
  endtask
  task automatic complete_run();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial forever #4 clock_i = ~clock_i;
  initial begin
    repeat (3000) @(posedge clock_i);
    failures++;
    complete_run();
  end
  initial begin
    repeat (20) @(negedge clock_i);
    chk("stall in reset", stall_o, 1'b0);
    chk("forward in reset", fwd_a_o === phi_pkg::PHI_FWD_NONE, 1'b1);
    sys_rst_i = 1'b0;
    // The consumer is held three cycles, which covers the longest stall.
    foreach (rows[r]) begin
      send(mk(rows[r].op_a, 5'h01, rows[r].rg));
      send(mk(rows[r].op_b, rows[r].rg_b, 5'h07));
      send(decode_i);
      chk("stall", stall_o, rows[r].exp);
      chk("bubble", interlock_bubble_o, rows[r].exp);
      send(decode_i);
      repeat (6) send('0);
      $display("row %0d done", r);
    end
    send(mk(phi_pkg::PHI_OP_LOAD, 5'h01, 5'h06));
    send(mk(phi_pkg::PHI_OP_ALU, 5'h08, 5'h09));
    send(mk(phi_pkg::PHI_OP_ALU, 5'h06, 5'h0A));
    send('0);
    chk("load at distance two", stall_o, 1'b0);
    chk("load forward at distance two", fwd_a_o === phi_pkg::PHI_FWD_ACCESS, 1'b1);
    repeat (6) send('0);
    product_ready_i = 1'b0;
    send(mk(phi_pkg::PHI_OP_MULW, 5'h01, 5'h05));
    send(mk(phi_pkg::PHI_OP_ALU, 5'h05, 5'h07));
    send(decode_i);
    chk("word product wait", stall_o, 1'b1);
    product_ready_i = 1'b1;
    send(decode_i);
    chk("word product released", stall_o, 1'b0);
    chk("word product forward", fwd_a_o === phi_pkg::PHI_FWD_SECOND, 1'b1);
    repeat (6) send('0);
    product_ready_i = 1'b0;
    send(mk(phi_pkg::PHI_OP_MULW, 5'h01, 5'h05));
    repeat (4) send(mk(phi_pkg::PHI_OP_ALU, 5'h08, 5'h09));
    send(mk(phi_pkg::PHI_OP_ALU, 5'h05, 5'h07));
    send('0);
    chk("word product at distance five", stall_o, 1'b0);
    product_ready_i = 1'b1;
    repeat (6) send('0);
    send(mk(phi_pkg::PHI_OP_SYSW, 5'h00, 5'h00));
    repeat (2) send(mk(phi_pkg::PHI_OP_ALU, 5'h08, 5'h09));
    send(mk(phi_pkg::PHI_OP_SYSR, 5'h00, 5'h00));
    send('0);
    chk("system read at distance three", stall_o, 1'b0);
    repeat (6) send('0);
    $display("distance tests done");
    foreach (br_tab[k]) begin
      @(negedge clock_i);
      {branch_taken_i, target_long_i, addr_bit1_i, addr_bit0_i} = br_tab[k];
      @(negedge clock_i);
      branch_taken_i = 1'b0;
      chk("refetch", refetch_o, k == 0);
      repeat (4) @(negedge clock_i);
    end
    $display("branch target tests done");
    complete_run();
  end
endmodule
